// ===== alc_defines.vh
// register map, field layout, reset values and sample limits of the checker
`ifndef ALC_DEFINES_VH
`define ALC_DEFINES_VH

`define ALC_OFS_MODE 8'h00
`define ALC_OFS_CHAN 8'h04
`define ALC_OFS_TOT_LO 8'h08
`define ALC_OFS_TOT_HI 8'h0c
`define ALC_OFS_PRE_LO 8'h10
`define ALC_OFS_PRE_HI 8'h14
`define ALC_OFS_POST_LO 8'h18
`define ALC_OFS_POST_HI 8'h1c
`define ALC_OFS_BLK_LO 8'h20
`define ALC_OFS_BLK_HI 8'h24
`define ALC_OFS_REP 8'h28
`define ALC_OFS_CTRL 8'h2c
`define ALC_OFS_STAT 8'h30
`define ALC_OFS_USE_LO 8'h34
`define ALC_OFS_USE_HI 8'h38
`define ALC_OFS_EFFPRE_LO 8'h3c
`define ALC_OFS_EFFPRE_HI 8'h40

// mode register: bit 2 streaming, bits 1:0 sub-mode
`define ALC_MODE_STREAM_BIT 2
`define ALC_SUB_SINGLE 2'h0
`define ALC_SUB_MULTI 2'h1
`define ALC_SUB_GATE 2'h2
`define ALC_SUB_DUAL 2'h3

// control register bits
`define ALC_CTRL_START_BIT 0
`define ALC_CTRL_CLR_BIT 1

// status register bits
`define ALC_ST_TOT_BIT 0
`define ALC_ST_PRE_BIT 1
`define ALC_ST_POST_BIT 2
`define ALC_ST_BLK_BIT 3
`define ALC_ST_CHAN_BIT 4
`define ALC_ST_ANY_BIT 5
`define ALC_ST_REFUSED_BIT 6

// reset values
`define ALC_RST_MODE 3'h0
`define ALC_RST_CHAN 3'h0
`define ALC_RST_TOT 34'h000000400
`define ALC_RST_PRE 34'h000000004
`define ALC_RST_POST 34'h000000200
`define ALC_RST_BLK 34'h000000400
`define ALC_RST_REP 32'h00000000

// limits in samples per channel; k is 1024
`define ALC_BYTES_PER_SAMPLE_SHIFT 1
`define ALC_MEM_BASE 34'h002000000
`define ALC_MEM_CODE_MAX 3'h6
`define ALC_CHAN_CODE_MAX 3'h4
`define ALC_TOT_MIN 34'h000000008
`define ALC_PRE_MIN 34'h000000004
`define ALC_POST_MIN 34'h000000004
`define ALC_BLK_MIN 34'h000000008
`define ALC_BIG_MAX 34'h1fffffffc
`define ALC_MEM_GUARD 34'h000000004
`define ALC_PRE_MAX_1CH 34'h000001ff0
`define ALC_PRE_MAX_2CH 34'h000000ff8
`define ALC_PRE_MAX_4CH 34'h0000007fc
`define ALC_PRE_MAX_8CH 34'h0000003fc
`define ALC_PRE_MAX_16CH 34'h0000001fc
`define ALC_STEP_BITS 2

`endif

// ===== alc_range_check.v
// one setting against its lower bound, upper bound and step of 4
`timescale 1ns/1ps
module alc_range_check #(
  parameter W = 34,
  parameter STEP_BITS = 2
) (
  input wire [W-1:0] value,
  input wire [W-1:0] minVal,
  input wire [W-1:0] maxVal,
  input wire enable,
  output wire bad
);
  // unused settings never flag
  assign bad = enable & ((value < minVal) | (value > maxVal) |
    (value[STEP_BITS-1:0] != {STEP_BITS{1'b0}}));
endmodule // alc_range_check

// ===== alc_limit_checker.v
// acquisition length limit checker with register port and start gate
//
// Overview of operation
// - memory usage counts two bytes per sample
// - total capped at memory over channel count
// - total min 8, post min 4
// - lengths in steps of 4, repeats 1
// - all length settings are per-channel sample counts
// - pre 4 to channel-dependent maximum
// - standard single derives pre, ignores block
// - streaming ignores total, repeat 0 infinite
// - block 8 to Mem over twice channels in multi and dual
// - total, multi/dual block and non-streaming gate/multi/dual post maxima scale from installed memory
// - multi and dual derive pre from block
`timescale 1ns/1ps
`include "alc_defines.vh"
module alc_limit_checker #(
  parameter AW = 8,
  parameter DW = 32,
  parameter SW = 34
) (
  input wire core_clk,
  input wire reset,
  input wire ce,
  input wire [AW-1:0] regAddr,
  input wire [DW-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [DW-1:0] regRdData,
  input wire [2:0] installedMemCode,
  output reg acqStart,
  output reg settingsError
);

  reg [2:0] memSync1_reg;
  reg [2:0] memSync2_reg;
  reg [2:0] mode_reg;
  reg [2:0] chan_reg;
  reg [SW-1:0] tot_reg;
  reg [SW-1:0] pre_reg;
  reg [SW-1:0] post_reg;
  reg [SW-1:0] blk_reg;
  reg [31:0] rep_reg;
  reg refused_reg;
  reg [DW-1:0] rdData_next;

  wire stream = mode_reg[`ALC_MODE_STREAM_BIT];
  wire [1:0] sub = mode_reg[1:0];
  wire single = (sub == `ALC_SUB_SINGLE);
  wire multiDual = (sub == `ALC_SUB_MULTI) | (sub == `ALC_SUB_DUAL);
  wire gate = (sub == `ALC_SUB_GATE);
  wire stdSingle = ~stream & single;

  // installed memory, a strap from the board, is resynchronised
  always @(posedge core_clk) begin
    if (reset) begin
      memSync1_reg <= 3'h0;
      memSync2_reg <= 3'h0;
    end else if (ce) begin
      memSync1_reg <= installedMemCode;
      memSync2_reg <= memSync1_reg;
    end
  end

  // out-of-range codes clamp to the largest fitted memory
  wire [2:0] memCode = (memSync2_reg > `ALC_MEM_CODE_MAX) ?
    `ALC_MEM_CODE_MAX : memSync2_reg;
  // channel code 0..4 means 1,2,4,8,16 channels; other codes are an error
  wire chanBad = (chan_reg > `ALC_CHAN_CODE_MAX);
  wire [2:0] chanShift = chanBad ? `ALC_CHAN_CODE_MAX : chan_reg;

  wire [SW-1:0] memSamples = `ALC_MEM_BASE << memCode;
  wire [SW-1:0] memPerChan = memSamples >> chanShift;
  wire [SW-1:0] memHalfChan = memSamples >> (chanShift + 3'h1);

  reg [SW-1:0] preMax;
  always @* begin
    case (chanShift)
      3'h0: preMax = `ALC_PRE_MAX_1CH;
      3'h1: preMax = `ALC_PRE_MAX_2CH;
      3'h2: preMax = `ALC_PRE_MAX_4CH;
      3'h3: preMax = `ALC_PRE_MAX_8CH;
      default: preMax = `ALC_PRE_MAX_16CH;
    endcase
  end

  // pre value used for checking and reporting
  wire blkUnder = (post_reg > blk_reg);
  wire totUnder = (post_reg > tot_reg);
  reg [SW-1:0] effPre;
  reg preUnder;
  always @* begin
    effPre = pre_reg;
    preUnder = 1'b0;
    if (stdSingle) begin
      // defined by post: whatever of the record precedes the event
      effPre = totUnder ? {SW{1'b0}} : tot_reg - post_reg;
    end else if (multiDual) begin
      effPre = blkUnder ? {SW{1'b0}} : blk_reg - post_reg;
      preUnder = blkUnder;
    end
  end

  // the highest channel counts drop the four-sample guard
  reg [SW-1:0] postMax;
  always @* begin
    if (stream | single) begin
      postMax = `ALC_BIG_MAX;
    end else if (multiDual) begin
      postMax = (chanShift >= 3'h3) ? memHalfChan :
        memHalfChan - `ALC_MEM_GUARD;
    end else begin
      postMax = (chanShift == 3'h4) ? memPerChan :
        memPerChan - `ALC_MEM_GUARD;
    end
  end

  wire [SW-1:0] blkMax = multiDual ? memHalfChan : `ALC_BIG_MAX;
  wire totEn = ~stream;
  wire preEn = ~stdSingle;
  wire postEn = ~(stream & single);
  wire blkEn = multiDual | (stream & single);

  wire totBad;
  wire preRangeBad;
  wire postBad;
  wire blkBad;

  alc_range_check #(.W(SW), .STEP_BITS(`ALC_STEP_BITS)) uTot (
    .value(tot_reg),
    .minVal(`ALC_TOT_MIN),
    .maxVal(memPerChan),
    .enable(totEn),
    .bad(totBad)
  );

  alc_range_check #(.W(SW), .STEP_BITS(`ALC_STEP_BITS)) uPre (
    .value(effPre),
    .minVal(`ALC_PRE_MIN),
    .maxVal(preMax),
    .enable(preEn),
    .bad(preRangeBad)
  );

  alc_range_check #(.W(SW), .STEP_BITS(`ALC_STEP_BITS)) uPost (
    .value(post_reg),
    .minVal(`ALC_POST_MIN),
    .maxVal(postMax),
    .enable(postEn),
    .bad(postBad)
  );

  alc_range_check #(.W(SW), .STEP_BITS(`ALC_STEP_BITS)) uBlk (
    .value(blk_reg),
    .minVal(`ALC_BLK_MIN),
    .maxVal(blkMax),
    .enable(blkEn),
    .bad(blkBad)
  );

  // repeat count: every 32-bit value is legal, 0 runs until stopped
  wire preBad = preRangeBad | (preEn & preUnder);
  wire anyBad = totBad | preBad | postBad | blkBad | chanBad;

  // usage in bytes of the whole record across all channels
  wire [SW+5:0] useBytes = ({6'h00, tot_reg} << chanShift) <<
    `ALC_BYTES_PER_SAMPLE_SHIFT;

  wire wrHit = ce & regWrite;
  wire startReq = wrHit & (regAddr == `ALC_OFS_CTRL) &
    regWrData[`ALC_CTRL_START_BIT];
  wire clrReq = wrHit & (regAddr == `ALC_OFS_CTRL) &
    regWrData[`ALC_CTRL_CLR_BIT];

  // high words keep only the bits above 32
  always @(posedge core_clk) begin
    if (reset) begin
      mode_reg <= `ALC_RST_MODE;
      chan_reg <= `ALC_RST_CHAN;
      tot_reg <= `ALC_RST_TOT;
      pre_reg <= `ALC_RST_PRE;
      post_reg <= `ALC_RST_POST;
      blk_reg <= `ALC_RST_BLK;
      rep_reg <= `ALC_RST_REP;
    end else if (wrHit) begin
      case (regAddr)
        `ALC_OFS_MODE: mode_reg <= regWrData[2:0];
        `ALC_OFS_CHAN: chan_reg <= regWrData[2:0];
        `ALC_OFS_TOT_LO: tot_reg[31:0] <= regWrData;
        `ALC_OFS_TOT_HI: tot_reg[SW-1:32] <= regWrData[SW-33:0];
        `ALC_OFS_PRE_LO: pre_reg[31:0] <= regWrData;
        `ALC_OFS_PRE_HI: pre_reg[SW-1:32] <= regWrData[SW-33:0];
        `ALC_OFS_POST_LO: post_reg[31:0] <= regWrData;
        `ALC_OFS_POST_HI: post_reg[SW-1:32] <= regWrData[SW-33:0];
        `ALC_OFS_BLK_LO: blk_reg[31:0] <= regWrData;
        `ALC_OFS_BLK_HI: blk_reg[SW-1:32] <= regWrData[SW-33:0];
        `ALC_OFS_REP: rep_reg <= regWrData;
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // start is judged on the settings as they stand in that cycle
  always @(posedge core_clk) begin
    if (reset) begin
      acqStart <= 1'b0;
      refused_reg <= 1'b0;
      settingsError <= 1'b0;
    end else if (ce) begin
      acqStart <= startReq & ~anyBad;
      settingsError <= anyBad;
      // a refusal in the clearing cycle wins so it is not lost
      if (startReq & anyBad) begin
        refused_reg <= 1'b1;
      end else if (clrReq) begin
        refused_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rdData_next = {DW{1'b0}};
    case (regAddr)
      `ALC_OFS_MODE: rdData_next = {29'h0, mode_reg};
      `ALC_OFS_CHAN: rdData_next = {29'h0, chan_reg};
      `ALC_OFS_TOT_LO: rdData_next = tot_reg[31:0];
      `ALC_OFS_TOT_HI: rdData_next = {30'h0, tot_reg[SW-1:32]};
      `ALC_OFS_PRE_LO: rdData_next = pre_reg[31:0];
      `ALC_OFS_PRE_HI: rdData_next = {30'h0, pre_reg[SW-1:32]};
      `ALC_OFS_POST_LO: rdData_next = post_reg[31:0];
      `ALC_OFS_POST_HI: rdData_next = {30'h0, post_reg[SW-1:32]};
      `ALC_OFS_BLK_LO: rdData_next = blk_reg[31:0];
      `ALC_OFS_BLK_HI: rdData_next = {30'h0, blk_reg[SW-1:32]};
      `ALC_OFS_REP: rdData_next = rep_reg;
      `ALC_OFS_STAT: begin
        rdData_next[`ALC_ST_TOT_BIT] = totBad;
        rdData_next[`ALC_ST_PRE_BIT] = preBad;
        rdData_next[`ALC_ST_POST_BIT] = postBad;
        rdData_next[`ALC_ST_BLK_BIT] = blkBad;
        rdData_next[`ALC_ST_CHAN_BIT] = chanBad;
        rdData_next[`ALC_ST_ANY_BIT] = anyBad;
        rdData_next[`ALC_ST_REFUSED_BIT] = refused_reg;
      end
      `ALC_OFS_USE_LO: rdData_next = useBytes[31:0];
      `ALC_OFS_USE_HI: rdData_next = {24'h0, useBytes[SW+5:32]};
      `ALC_OFS_EFFPRE_LO: rdData_next = effPre[31:0];
      `ALC_OFS_EFFPRE_HI: rdData_next = {30'h0, effPre[SW-1:32]};
      default: rdData_next = {DW{1'b0}};
    endcase
  end

  // read data stands in the cycle after the strobe, and holds while ce is low
  always @(posedge core_clk) begin
    if (reset) begin
      regRdData <= {DW{1'b0}};
    end else if (ce) begin
      regRdData <= regRead ? rdData_next : {DW{1'b0}};
    end
  end

endmodule // alc_limit_checker

// ===== alc_limit_monitor.sv
// port assertions for the limit checker
`timescale 1ns/1ps
module alc_limit_monitor (
  input wire core_clk,
  input wire reset,
  input wire ce,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdData,
  input wire [2:0] installedMemCode,
  input wire acqStart,
  input wire settingsError
);
  wire goNow = ce && regWrite && regAddr == 8'h2c && regWrData[0];
  wire rdNow = ce && regRead;
  wire rdZero = rdNow && (regAddr == 8'h2c || regAddr > 8'h40);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_idle;
    ce && !regWrite;
  endsequence
  sequence s_go;
    goNow;
  endsequence
  property p_cause;
    acqStart |-> $past(goNow);
  endproperty
  a_cause: assert property (p_cause) else $error("stray start");
  property p_clean;
    acqStart |-> !settingsError;
  endproperty
  a_clean: assert property (p_clean) else $error("start on error");
  // settings unchanged for a cycle, so the flag matches the live check
  property p_follow;
    s_idle ##1 s_go |=> acqStart == !$past(settingsError);
  endproperty
  a_follow: assert property (p_follow) else $error("bad gate");
  property p_rd;
    regRdData != 0 |-> $past(rdNow) || !$past(ce);
  endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_zero;
    rdZero |=> regRdData == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("hole not zero");
  property p_freeze;
    !ce |=> $stable(settingsError) && $stable(regRdData);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved, ce low");
  property p_even;
    rdNow && regAddr == 8'h34 |=> !regRdData[0];
  endproperty
  a_even: assert property (p_even) else $error("odd byte count");
  property p_reset;
    disable iff (1'b0) reset |=> regRdData == 0 && !acqStart && !settingsError;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values");
endmodule // alc_limit_monitor

bind alc_limit_checker alc_limit_monitor i_mon (.core_clk(core_clk),
  .reset(reset), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .installedMemCode(installedMemCode), .acqStart(acqStart),
  .settingsError(settingsError));

// ===== alc_limit_checker_tb_top.sv
// self-checking bench for the limit checker against a reference model
`timescale 1ns/1ps
module alc_limit_checker_tb_top;
  localparam longint G8 = 64'h1fffffffc;
  logic core_clk = 0, reset = 1, ce = 1, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWrData = 0, regRdData, d;
  logic [2:0] installedMemCode = 0;
  logic acqStart, settingsError;
  logic [7:0] ra[6] = '{8'h00, 8'h08, 8'h18, 8'h30, 8'h44, 8'h2c};
  logic [31:0] rx[6] = '{0, 32'h400, 32'h200, 0, 0, 0};
  int n_fail = 0, n_tests = 0;
  longint md, c, mem, tot, pre, post, blk, e, u, ep;
  always #5 core_clk = ~core_clk;
  alc_limit_checker i_alc_limit_checker (.core_clk(core_clk),
    .reset(reset), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .installedMemCode(installedMemCode), .acqStart(acqStart),
    .settingsError(settingsError));
  task chk(input logic [39:0] s, input logic [39:0] x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWrite <= 1;
    regAddr <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWrite <= 0;
  endtask
  task w34(input logic [7:0] a, input logic [33:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {30'h0, v[33:32]});
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    regRead <= 1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 0;
    #1 d = regRdData;
  endtask
  function automatic bit bad(longint v, longint lo, longint hi);
    return v < lo || v > hi || v % 4 != 0;
  endfunction
  function automatic longint pmax(longint n);
    return (8192 >> n) - (n < 2 ? 16 >> n : 4);
  endfunction
  // near-boundary pick: either limit, shifted a step, sometimes off-grid
  function automatic longint pk(longint lo, longint hi);
    return ($urandom % 2 ? lo : hi) + 4 * ($urandom % 3) - 4
      + ($urandom % 5 == 0);
  endfunction
  function automatic longint model();
    longint s, sb, mm, p, pmx, bmx, er;
    s = md >> 2;
    sb = md % 4;
    mm = mem >> c;
    pmx = G8;
    bmx = 0;
    if (sb % 2) begin
      pmx = s ? G8 : (mm >> 1) - (c < 3 ? 4 : 0);
      bmx = mm >> 1;
    end
    if (sb == 2 && s == 0) pmx = mm - (c < 4 ? 4 : 0);
    if (sb == 0 && s) begin
      pmx = 0;
      bmx = G8;
    end
    p = sb % 2 ? blk - post : pre;
    er = s == 0 && bad(tot, 8, mm);
    er |= (md != 0 && bad(p, 4, pmax(c))) << 1;
    er |= (pmx != 0 && bad(post, 4, pmx)) << 2;
    er |= (bmx != 0 && bad(blk, 8, bmx)) << 3;
    return er | (er != 0) << 5;
  endfunction
  task results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(113));
    repeat (16) @(posedge core_clk);
    reset <= 0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, rx[i]);
    end
    chk(settingsError, 0);
    $display("test reset done");
    ce <= 0;
    wr(8'h00, 7);
    ce <= 1;
    rd(8'h00);
    chk(d, 0);
    wr(8'h04, 5);
    rd(8'h30);
    chk(d[5:4], 3);
    $display("test ports done");
    repeat (60) begin
      mem = $urandom % 7;
      installedMemCode <= mem[2:0];
      mem = 64'h2000000 << mem;
      md = $urandom % 8;
      c = $urandom % 5;
      tot = pk(8, mem >> c);
      pre = pk(4, pmax(c));
      post = pk(4, mem >> c + 1);
      blk = pk(8, mem >> c + 1);
      wr(8'h00, md[31:0]);
      wr(8'h04, c[31:0]);
      w34(8'h08, tot[33:0]);
      w34(8'h10, pre[33:0]);
      w34(8'h18, post[33:0]);
      w34(8'h20, blk[33:0]);
      u = $urandom;
      wr(8'h28, u[31:0]);
      rd(8'h28);
      chk(d, u[31:0]);
      e = model();
      // effective pre: derived from post in std single, from block in multi and dual
      if (md == 0) ep = post > tot ? 0 : tot - post;
      else if (md % 2) ep = post > blk ? 0 : blk - post;
      else ep = pre;
      rd(8'h3c);
      chk(d, ep[31:0]);
      rd(8'h40);
      chk(d, ep[33:32]);
      rd(8'h30);
      chk(d, e[39:0]);
      chk(settingsError, e[5]);
      u = tot << (c + 1);
      rd(8'h34);
      chk(d, u[31:0]);
      rd(8'h38);
      chk(d, u[39:32]);
      wr(8'h2c, 1);
      #1 chk(acqStart, e == 0);
      rd(8'h30);
      chk(d[6], e != 0);
      wr(8'h2c, 2);
    end
    $display("test random done");
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule // alc_limit_checker_tb_top
